// [logic/pdial_core.sv]
// Pulse dialler: keypad debounce, redial memory, digit buffer, pulse output
// Overview of operation
// - Redial memory keeps up to 23 keycodes of the last number.
// - System tick divided from clock; speed select picks a pulse rate of 10 Hz or 932 Hz.
// - Line power low: tick stops, keys ignored, debounce and pulse logic frozen, memory kept.
// - Line power high: tick runs, logic released, keys accepted.
// - Low longer than break delay gives internal reset and standby.
// - Exactly one column high and one row low is a key; else rejected.
// - Key stored only after four or five closed tick periods.
// - Next key waits until contact open three or four tick periods.
// - Closures are sampled on system ticks, one period uncertainty.
// - Accepted keycode written at store index, then index incremented.
// - Each fetch increments recall index; unequal indices mean pending.
// - From the 23rd key the store index wraps and overwrites; redial blocked until next call.
// - First non-redial key resets store index, stores at zero, increments.
// - First key redial keeps store index and pulses all stored digits.
// - Keys ignored during redial; accepted again once all are pulsed.
// - Pause input stops dialling after current digit or after a gap.
// - Combined drive equals line pulse AND silence.
// - Second silence output is the inverse of silence.
// - Break delay is 1,6 pulse periods of continuous low power.
// - Silence rises once a code is stored, falls when all pulsed.
// - Each digit loads a counter producing that many timed pulses.
// - After pause, resume only once pause is low and a gap elapsed.
`timescale 1ns/1ps
`default_nettype none

// Simple flop FIFO, stalls its filler when full
module pdial_fifo #(
	parameter int WIDTH = 4,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] store_reg [DEPTH];
	logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
	logic [AW:0] cnt_reg, cnt_next;
	logic push, pop;

	assign in_ready = (cnt_reg != DEPTH[AW:0]);
	assign out_valid = (cnt_reg != '0);
	assign out_data = store_reg[rd_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Pointer and fill count update
	always_comb begin
		wr_next = push ? wr_reg + 1'b1 : wr_reg;
		rd_next = pop ? rd_reg + 1'b1 : rd_reg;
		cnt_next = cnt_reg;
		if (push && !pop) begin
			cnt_next = cnt_reg + 1'b1;
		end else if (pop && !push) begin
			cnt_next = cnt_reg - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
		end
	end

	// Storage needs no reset; only counted entries are read
	always_ff @(posedge clk) begin
		if (push) begin
			store_reg[wr_reg] <= in_data;
		end
	end
endmodule

module pdial_core
	import pdial_pkg::*;
#(
	parameter int DIV_NORM = DIV_NORM_CYCLES,
	parameter int DIV_TEST = DIV_TEST_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Line and mode inputs
	input wire logic line_power_present,
	input wire logic pulse_speed_select,
	input wire logic dial_pause,
	// Keypad matrix
	input wire logic [2:0] keypad_column,
	input wire logic [3:0] keypad_row,
	// Line outputs
	output logic line_pulse_out,
	output logic silence_out,
	output logic silence_n_out,
	output logic pulse_hush_drive
);
	// Divider and power break state
	logic [31:0] div_reg, div_next, brk_reg, brk_next;
	logic tick, brk_pulse, core_rst_n;
	logic [31:0] div_len, brk_len;

	assign div_len = pulse_speed_select ? DIV_TEST : DIV_NORM;
	assign brk_len = div_len * POWER_BREAK_TICKS;
	// Runs when powered
	// A rate change may leave the count past the new end; catch up at once
	assign tick = line_power_present && (div_reg >= div_len - 1);
	assign brk_pulse = !line_power_present && (brk_reg == brk_len - 1);
	assign core_rst_n = rst_n && !brk_pulse;

	// Divider stops with line power; break counter runs only while low
	always_comb begin
		div_next = div_reg + 1;
		if (!line_power_present || tick) begin
			div_next = '0;
		end
		brk_next = '0;
		if (!line_power_present) begin
			brk_next = (brk_reg >= brk_len) ? brk_reg : brk_reg + 1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div_reg <= '0;
			brk_reg <= '0;
		end else begin
			div_reg <= div_next;
			brk_reg <= brk_next;
		end
	end

	// Keypad decode: columns idle low, rows idle high
	logic key_valid;
	logic [3:0] key_code;
	logic [1:0] col_idx, row_idx;
	logic col_one, row_one;

	always_comb begin
		col_idx = 2'h0;
		row_idx = 2'h0;
		col_one = 1'b1;
		row_one = 1'b1;
		case (keypad_column)
			3'h1: col_idx = 2'h0;
			3'h2: col_idx = 2'h1;
			3'h4: col_idx = 2'h2;
			default: col_one = 1'b0;
		endcase
		case (~keypad_row)
			4'h1: row_idx = 2'h0;
			4'h2: row_idx = 2'h1;
			4'h4: row_idx = 2'h2;
			4'h8: row_idx = 2'h3;
			default: row_one = 1'b0;
		endcase
		if (row_idx == 2'h3) begin
			key_code = (col_idx == 2'h0) ? KEY_STAR :
				(col_idx == 2'h1) ? KEY_ZERO : KEY_REDIAL;
		end else begin
			key_code = 4'(row_idx * 3 + col_idx + 1);
		end
	end

	logic redial_reg, redial_next;
	assign key_valid = col_one && row_one && line_power_present && !redial_reg;

	// Debounce, sampled only on system ticks
	pdial_key_state_t kst_reg, kst_next;
	logic [2:0] kcnt_reg, kcnt_next;
	logic [3:0] kcode_reg, kcode_next;
	logic key_accept;

	always_comb begin
		kst_next = kst_reg;
		kcnt_next = kcnt_reg;
		kcode_next = kcode_reg;
		key_accept = 1'b0;
		if (tick) begin
			case (kst_reg)
				KEY_IDLE: begin
					if (key_valid) begin
						kst_next = KEY_CLOSED;
						kcnt_next = 3'h1;
						kcode_next = key_code;
					end
				end
				KEY_CLOSED: begin
					if (!key_valid || key_code != kcode_reg) begin
						kst_next = KEY_IDLE;
					end else if (kcnt_reg + 3'h1 == KEY_ACCEPT_TICKS) begin
						key_accept = 1'b1;
						kst_next = KEY_OPEN;
						kcnt_next = 3'h0;
					end else begin
						kcnt_next = kcnt_reg + 3'h1;
					end
				end
				KEY_OPEN: begin
					if (keypad_column != 3'h0 || keypad_row != 4'hF) begin
						kcnt_next = 3'h0;
					end else if (kcnt_reg + 3'h1 == KEY_RELEASE_TICKS) begin
						kst_next = KEY_IDLE;
					end else begin
						kcnt_next = kcnt_reg + 3'h1;
					end
				end
				default: kst_next = KEY_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!core_rst_n) begin
			kst_reg <= KEY_IDLE;
			kcnt_reg <= 3'h0;
			kcode_reg <= 4'h0;
		end else begin
			kst_reg <= kst_next;
			kcnt_reg <= kcnt_next;
			kcode_reg <= kcode_next;
		end
	end

	// Redial memory and its two indices
	logic [3:0] mem_reg [MEM_DEPTH];
	logic [IDX_W-1:0] store_index_reg, store_index_next;
	logic [IDX_W-1:0] recall_index_reg, recall_index_next;
	logic overflow_reg, overflow_next, first_key_reg, first_key_next;
	logic [IDX_W-1:0] wr_idx;
	logic mem_we, fetch, pending, fifo_in_ready, fifo_out_valid, pop;
	logic [3:0] fifo_out_data;
	logic pulse_idle;

	assign pending = (recall_index_reg != store_index_reg);

	always_comb begin
		store_index_next = store_index_reg;
		recall_index_next = recall_index_reg;
		overflow_next = overflow_reg;
		first_key_next = first_key_reg;
		redial_next = redial_reg;
		mem_we = 1'b0;
		fetch = 1'b0;
		wr_idx = first_key_reg ? '0 : store_index_reg;
		if (key_accept && first_key_reg && kcode_reg == KEY_REDIAL) begin
			if (!overflow_reg && store_index_reg != '0) begin
				redial_next = 1'b1;
				recall_index_next = '0;
				first_key_next = 1'b0;
			end
		end else if (key_accept) begin
			mem_we = 1'b1;
			first_key_next = 1'b0;
			if (first_key_reg) begin
				overflow_next = 1'b0;
				recall_index_next = '0;
			end
			if (wr_idx == IDX_LAST) begin
				store_index_next = '0;
				overflow_next = 1'b1;
			end else begin
				store_index_next = wr_idx + 1'b1;
			end
		end
		if (!(key_accept && first_key_reg) && pending && fifo_in_ready) begin
			fetch = 1'b1;
			recall_index_next = (recall_index_reg == IDX_LAST) ?
				'0 : recall_index_reg + 1'b1;
		end
		if (redial_reg && !pending && !fifo_out_valid && pulse_idle) begin
			redial_next = 1'b0;
		end
	end

	// Store index and overflow survive the power break reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			store_index_reg <= '0;
			overflow_reg <= 1'b0;
		end else begin
			store_index_reg <= store_index_next;
			overflow_reg <= overflow_next;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			recall_index_reg <= '0;
			first_key_reg <= 1'b1;
			redial_reg <= 1'b0;
		end else if (brk_pulse) begin
			recall_index_reg <= store_index_reg;
			first_key_reg <= 1'b1;
			redial_reg <= 1'b0;
		end else begin
			recall_index_reg <= recall_index_next;
			first_key_reg <= first_key_next;
			redial_reg <= redial_next;
		end
	end

	// Memory contents are never reset, so a redial survives standby
	always_ff @(posedge clk) begin
		if (mem_we) begin
			mem_reg[wr_idx] <= kcode_reg;
		end
	end

	// Fetched digits wait here; a held pause backs up into the fetcher
	pdial_fifo #(
		.WIDTH(CODE_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst_n(core_rst_n),
		.in_valid(fetch),
		.in_ready(fifo_in_ready),
		.in_data(mem_reg[recall_index_reg]),
		.out_valid(fifo_out_valid),
		.out_ready(pop),
		.out_data(fifo_out_data)
	);

	// Pulse generator, steps on system ticks only
	pdial_pulse_state_t pst_reg, pst_next;
	logic [3:0] ptime_reg, ptime_next, pcount_reg, pcount_next;
	logic silence_reg, silence_next, line_pulse_reg, line_pulse_next;
	logic hush_reg, hush_next;

	assign pulse_idle = (pst_reg == PUL_IDLE);

	always_comb begin
		pst_next = pst_reg;
		ptime_next = ptime_reg;
		pcount_next = pcount_reg;
		pop = 1'b0;
		if (tick) begin
			case (pst_reg)
				PUL_IDLE: begin
					if (fifo_out_valid) begin
						pst_next = PUL_GAP;
						ptime_next = 4'h0;
					end
				end
				PUL_GAP: begin
					if (ptime_reg + 4'h1 != DIGIT_GAP_TICKS) begin
						ptime_next = ptime_reg + 4'h1;
					end else if (dial_pause) begin
						pst_next = PUL_HOLD;
					end else if (fifo_out_valid) begin
						pop = 1'b1;
						ptime_next = 4'h0;
						pcount_next = (fifo_out_data > KEY_ZERO) ?
							4'h0 : fifo_out_data;
						pst_next = (fifo_out_data > KEY_ZERO) ?
							PUL_GAP : PUL_BREAK;
					end else begin
						pst_next = PUL_IDLE;
					end
				end
				PUL_BREAK: begin
					ptime_next = ptime_reg + 4'h1;
					if (ptime_reg + 4'h1 == BREAK_TICKS) begin
						pst_next = PUL_MAKE;
						ptime_next = 4'h0;
						pcount_next = pcount_reg - 4'h1;
					end
				end
				PUL_MAKE: begin
					ptime_next = ptime_reg + 4'h1;
					if (ptime_reg + 4'h1 == MAKE_TICKS) begin
						ptime_next = 4'h0;
						if (pcount_reg != 4'h0) begin
							pst_next = PUL_BREAK;
						end else if (dial_pause) begin
							pst_next = PUL_HOLD;
						end else begin
							pst_next = PUL_GAP;
						end
					end
				end
				PUL_HOLD: begin
					if (!dial_pause) begin
						pst_next = PUL_GAP;
						ptime_next = 4'h0;
					end
				end
				default: pst_next = PUL_IDLE;
			endcase
		end
		line_pulse_next = (pst_next == PUL_BREAK);
		silence_next = pending || fifo_out_valid || (pst_next != PUL_IDLE);
		hush_next = line_pulse_next && silence_next;
	end

	always_ff @(posedge clk) begin
		if (!core_rst_n) begin
			pst_reg <= PUL_IDLE;
			ptime_reg <= 4'h0;
			pcount_reg <= 4'h0;
			line_pulse_reg <= 1'b0;
			silence_reg <= 1'b0;
			hush_reg <= 1'b0;
		end else begin
			pst_reg <= pst_next;
			ptime_reg <= ptime_next;
			pcount_reg <= pcount_next;
			line_pulse_reg <= line_pulse_next;
			silence_reg <= silence_next;
			hush_reg <= hush_next;
		end
	end

	assign line_pulse_out = line_pulse_reg;
	assign silence_out = silence_reg;
	assign silence_n_out = ~silence_reg;
	assign pulse_hush_drive = hush_reg;
endmodule

`default_nettype wire

// [common/pdial_pkg.sv]
// Constants, codes and timing for the pulse dialler with redial memory
package pdial_pkg;

	// Clock and dialling rates
	localparam int CLK_HZ = 100_000_000;
	localparam int PULSE_RATE_NORM_HZ = 10;
	localparam int PULSE_RATE_TEST_HZ = 932;
	// System ticks in one dialling pulse period
	localparam int TICKS_PER_PULSE = 10;
	localparam int DIV_NORM_CYCLES = CLK_HZ / (PULSE_RATE_NORM_HZ * TICKS_PER_PULSE);
	localparam int DIV_TEST_CYCLES = CLK_HZ / (PULSE_RATE_TEST_HZ * TICKS_PER_PULSE);

	// Power break delay: 1,6 pulse periods, about 160 ms at the normal rate
	localparam int POWER_BREAK_MS = 160;
	localparam int POWER_BREAK_TENTHS = 16;
	localparam int POWER_BREAK_TICKS = POWER_BREAK_TENTHS * TICKS_PER_PULSE / 10;

	// Key debounce, in system tick periods
	localparam logic [2:0] KEY_ACCEPT_TICKS = 3'h4;
	localparam logic [2:0] KEY_RELEASE_TICKS = 3'h3;

	// Pulse shape and digit gap, in system tick periods
	localparam logic [3:0] BREAK_TICKS = 4'h6;
	localparam logic [3:0] MAKE_TICKS = 4'h4;
	localparam logic [3:0] DIGIT_GAP_TICKS = 4'h8;

	// Redial memory and buffer
	localparam int MEM_DEPTH = 23;
	localparam int IDX_W = 5;
	localparam logic [IDX_W-1:0] IDX_LAST = 5'h16;
	localparam int CODE_W = 4;
	localparam int FIFO_DEPTH = 16;

	// Keycodes: digits carry their pulse count, zero gives ten
	localparam logic [3:0] KEY_ZERO = 4'hA;
	localparam logic [3:0] KEY_STAR = 4'hB;
	localparam logic [3:0] KEY_REDIAL = 4'hC;

	typedef enum logic [1:0] {KEY_IDLE, KEY_CLOSED, KEY_OPEN} pdial_key_state_t;
	typedef enum logic [2:0] {
		PUL_IDLE, PUL_GAP, PUL_BREAK, PUL_MAKE, PUL_HOLD
	} pdial_pulse_state_t;

endpackage

// [test/pdial_core_monitor.sv]
// Checker for the line outputs of the pulse dialler
`timescale 1ns/1ps
`default_nettype none
module pdial_core_monitor
	import pdial_pkg::*;
#(
	parameter int DIV_NORM = 4,
	parameter int DIV_TEST = 3
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Line and mode inputs
	input wire logic line_power_present,
	input wire logic pulse_speed_select,
	input wire logic dial_pause,
	// Keypad matrix
	input wire logic [2:0] keypad_column,
	input wire logic [3:0] keypad_row,
	// Line outputs
	input wire logic line_pulse_out,
	input wire logic silence_out,
	input wire logic silence_n_out,
	input wire logic pulse_hush_drive
);
	int div;
	int hi_reg;
	int lo_reg;
	int off_reg;

	// Clocks per tick follow the speed select, changed only when idle
	assign div = pulse_speed_select ? DIV_TEST : DIV_NORM;

	// Run lengths of line levels and of lost power
	always_ff @(posedge clk) begin
		hi_reg <= line_pulse_out ? hi_reg + 1 : 0;
		lo_reg <= line_pulse_out ? 0 : lo_reg + 1;
		off_reg <= line_power_present ? 0 : off_reg + 1;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_hush_and: assert property (
		pulse_hush_drive == (line_pulse_out && silence_out))
		else $error("combined drive differs from pulse and silence");
	a_silence_inv: assert property (
		silence_n_out != silence_out)
		else $error("second silence output not inverted");
	a_pulse_muted: assert property (
		line_pulse_out |-> silence_out)
		else $error("line break without silence");
	a_break_len: assert property (
		$fell(line_pulse_out) && $past(line_power_present)
		|-> hi_reg == BREAK_TICKS * div)
		else $error("line break of wrong length");
	a_make_len: assert property (
		$rose(line_pulse_out) |-> lo_reg >= MAKE_TICKS * div)
		else $error("make interval too short");
	a_break_reset: assert property (
		off_reg > POWER_BREAK_TICKS * div + 2
		|-> !silence_out && !line_pulse_out)
		else $error("no standby after long power loss");
	a_unpowered_quiet: assert property (
		$rose(line_pulse_out) |-> $past(line_power_present))
		else $error("break started without line power");
	a_gap_before_idle: assert property (
		$fell(silence_out) && $past(line_power_present)
		|-> lo_reg >= DIGIT_GAP_TICKS * div)
		else $error("silence ended before final gap");
endmodule
`default_nettype wire

// [test/pdial_keypad_model.sv]
// Keypad matrix and line switch model for the pulse dialler
`timescale 1ns/1ps
`default_nettype none
module pdial_keypad_model (
	// Clock
	input wire logic clk,
	// Key request from the bench
	input wire logic [3:0] key,
	input wire logic press,
	input wire logic two_cols,
	// Keypad pins
	output logic [2:0] keypad_column,
	output logic [3:0] keypad_row,
	// Line side
	input wire logic line_pulse_out,
	output logic digit_stb,
	output logic [7:0] digit_pulses
);
	int low_run = 0;
	logic last = 1'b0;
	logic [7:0] count = 8'h00;

	// One column high, or two when two_cols is set; one row low; open pins rest at their pulls
	always @(posedge clk) begin
		keypad_column <= press ? (3'h1 << (key % 3)) |
			(two_cols ? 3'h1 << ((key + 1) % 3) : 3'h0) : 3'h0;
		keypad_row <= press ? ~(4'h1 << (key / 3)) : 4'hF;
	end

	// Count breaks; a low run longer than a make ends the digit
	// The count is handed over with the strobe, so it stands while read
	always @(posedge clk) begin
		last <= line_pulse_out;
		digit_stb <= 1'b0;
		low_run <= line_pulse_out ? 0 : low_run + 1;
		if (line_pulse_out && !last)
			count <= count + 8'h01;
		if (low_run == 20 && count != 8'h00) begin
			digit_stb <= 1'b1;
			digit_pulses <= count;
			count <= 8'h00;
		end
	end
endmodule
`default_nettype wire

// [test/pulse_dialler_keypad_redial_tb.sv]
// Self-checking bench for the pulse dialler with redial memory
`timescale 1ns/1ps
`default_nettype none
module pulse_dialler_keypad_redial_tb;
	logic clk = 1'b0;
	logic rst_n, power, speed, pause, press, two_cols, stb;
	logic lp, sil, sil_n, hush;
	logic [3:0] key;
	logic [2:0] col;
	logic [3:0] row;
	logic [7:0] npul;
	int n_mismatch = 0;
	int n_checks = 0;
	int cyc = 0;
	int exp_q[$];
	int stored[$];
	bit first = 1'b1;
	bit ovf = 1'b0;

	always #5 clk = ~clk;

	pdial_core #(.DIV_NORM(4), .DIV_TEST(3)) pdial_core_inst (
		.clk(clk), .rst_n(rst_n), .line_power_present(power),
		.pulse_speed_select(speed), .dial_pause(pause),
		.keypad_column(col), .keypad_row(row), .line_pulse_out(lp),
		.silence_out(sil), .silence_n_out(sil_n), .pulse_hush_drive(hush));
	pdial_keypad_model pdial_keypad_model_inst (.clk(clk), .key(key),
		.press(press), .two_cols(two_cols), .keypad_column(col),
		.keypad_row(row), .line_pulse_out(lp), .digit_stb(stb),
		.digit_pulses(npul));

	task automatic chk(string what, logic [7:0] e, logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %0d seen %0d", what, e, g);
		end
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic clks(int n);
		repeat (n) @(posedge clk);
	endtask

	// Press for the given hold clocks, then leave it open long enough to release
	task automatic hit(int k, int hold);
		key <= k[3:0];
		press <= 1'b1;
		clks(hold);
		press <= 1'b0;
		clks(40);
	endtask

	// Reference model of the redial memory, then the key itself
	task automatic enter(int k);
		int p;
		p = (k == 10) ? 10 : (k < 9) ? k + 1 : 0;
		if (k == 11 && first) begin
			if (!ovf && stored.size() > 0) begin
				foreach (stored[j]) exp_q.push_back(stored[j]);
				first = 1'b0;
			end
		end else begin
			if (first)
				stored = {};
			if (first)
				ovf = 1'b0;
			first = 1'b0;
			stored.push_back(p);
			if (stored.size() > 23)
				ovf = 1'b1;
			if (p > 0)
				exp_q.push_back(p);
		end
		hit(k, 40);
	endtask

	// Power loss; above the break delay the next key opens a call
	task automatic pbreak(int n);
		power <= 1'b0;
		clks(n);
		power <= 1'b1;
		clks(8);
		if (n > 64)
			first = 1'b1;
	endtask

	task automatic idle(string name);
		for (int i = 0; i < 20000 && !(exp_q.size() == 0 && sil === 1'b0);
			i++)
			@(posedge clk);
		chk("pending", 8'h00, 8'(exp_q.size()));
		$display("test %s done", name);
	endtask

	// Each finished digit meets the oldest expected one; hangs are cut
	always @(posedge clk) begin
		if (stb === 1'b1)
			chk("digit", exp_q.size() ? 8'(exp_q.pop_front()) : 8'hFF, npul);
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			results();
		end
	end

	initial begin
		void'($urandom(32'h3f35_34aa));
		rst_n = 1'b0;
		power = 1'b1;
		speed = 1'b0;
		pause = 1'b0;
		press = 1'b0;
		two_cols = 1'b0;
		key = 4'h0;
		clks(16);
		rst_n <= 1'b1;
		clks(2);
		chk("silence", 8'h00, {7'h0, sil});
		chk("silence_n", 8'h01, {7'h0, sil_n});
		chk("line", 8'h00, {7'h0, lp});
		$display("test reset done");
		// Every digit key, the first one opening a call
		for (int k = 0; k < 11; k++)
			if (k != 9) enter(k);
		idle("digits");
		// Two columns at once, then too short a press
		two_cols <= 1'b1;
		hit(4, 40);
		two_cols <= 1'b0;
		hit(4, 8);
		clks(400);
		chk("silence", 8'h00, {7'h0, sil});
		idle("rejects");
		speed <= 1'b1;
		enter($urandom % 9);
		idle("test_rate");
		speed <= 1'b0;
		// A short dip keeps the call, a long one ends it
		pbreak(40);
		enter($urandom % 9);
		idle("short_dip");
		pbreak(100);
		enter(11);
		hit(0, 40);
		idle("redial");
		enter(1);
		idle("after_redial");
		pause <= 1'b1;
		enter($urandom % 9);
		enter($urandom % 9);
		clks(600);
		chk("held", 8'h02, 8'(exp_q.size()));
		pause <= 1'b0;
		idle("pause");
		// Overflowing memory blocks the next redial
		pbreak(100);
		for (int k = 0; k < 24; k++)
			enter(0);
		idle("fill");
		pbreak(100);
		enter(11);
		clks(400);
		chk("silence", 8'h00, {7'h0, sil});
		enter(2);
		idle("overflow");
		results();
	end
endmodule

bind pdial_core pdial_core_monitor #(.DIV_NORM(DIV_NORM),
	.DIV_TEST(DIV_TEST)) pdial_core_monitor_inst (.clk, .rst_n,
	.line_power_present, .pulse_speed_select, .dial_pause, .keypad_column,
	.keypad_row, .line_pulse_out, .silence_out, .silence_n_out,
	.pulse_hush_drive);
`default_nettype wire
